/* rtl/fault_restart_sequencer_defs.vh */
// constants for the fault restart sequencer: register map, field layout, counts
// assumes inclusion by its bare name from the rtl files
`ifndef FAULT_RESTART_SEQUENCER_DEFS_VH
`define FAULT_RESTART_SEQUENCER_DEFS_VH

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0C

`define CTRL_RESET 32'h0000_0000
`define IRQ_WIDTH 4
`define IRQ_OVERTEMP 0
`define IRQ_SHUTDOWN 1
`define IRQ_LOCKOUT 2
`define IRQ_RUN 3

`define COUNT_PRESET 4'h7
`define COUNT_RUN 4'h8
`define COUNT_WRAP 4'h1

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* rtl/level_sync.v */
// two flip-flop synchroniser for a bank of asynchronous level inputs
// assumes a single clock; reset value is a constant
`timescale 1ns/1ns
`include "fault_restart_sequencer_defs.vh"

module level_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // clock and reset
    input wire clock_in,
    input wire nrst_in,
    // levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1_q;
reg [WIDTH-1:0] stage2_q;

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
        always @(posedge clock_in or negedge nrst_in) begin
            if (!nrst_in) begin
                stage1_q[i] <= INIT[i];
                stage2_q[i] <= INIT[i];
            end else begin
                stage1_q[i] <= async_in[i];
                stage2_q[i] <= stage1_q[i];
            end
        end
    end
endgenerate

assign sync_out = stage2_q;

endmodule // level_sync

/* rtl/fault_restart_sequencer.v */
// fault restart sequencer: gate drive inhibit, start-up source and feedback clamp control
// assumes comparator flags are asynchronous levels and an AXI4-Lite master on clock_in
//
// Behaviour
// - over-temperature flag low inhibits gate drive
// - inhibit holds until temperature flag clears
// - start-up source keeps cycling during over-temperature
// - low supply inhibits drive, starts restart timer
// - eighth supply cycle enables a start attempt
// - shutdown pin low holds driver low within three clocks (two-stage synchroniser, registered output)
// - shutdown holds counter at seven
// - counter advances on start-up enable falling edge
// - release on rising supply keeps seven
// - release timing sets which down-slope resumes
// - power applied enables start-up source
// - lockout release disables source, enables PWM
// - counter preset seven at initial start-up
// - lockout trip re-enables charging, eight-cycle wait
// - feedback clamp on in standby, off when enabled
// - lockout forces gate drive low always
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "fault_restart_sequencer_defs.vh"

module fault_restart_sequencer (
    // clock and reset
    input wire clock_in,
    input wire nrst_in,
    // comparator flags, asynchronous levels
    input wire temp_ok_in,
    input wire supply_lockout_in,
    input wire feedback_shutdown_input_in,
    // pwm request from modulator
    input wire pwm_request_in,
    // power stage controls and interrupt request
    output reg gate_drive_out,
    output reg startup_enable_out,
    output reg pwm_enable_out,
    output reg clamp_enable_out,
    output reg irq_out,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output reg s_axi_awready_out,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output reg s_axi_wready_out,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output reg s_axi_arready_out,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in
);

// ----------------------------------------------------------------
// reset release
// ----------------------------------------------------------------
reg rst_meta_q;
reg rst_sync_q;
wire rst_n;

always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
        rst_meta_q <= 1'b0;
        rst_sync_q <= 1'b0;
    end else begin
        rst_meta_q <= 1'b1;
        rst_sync_q <= rst_meta_q;
    end
end

assign rst_n = rst_sync_q;

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
wire [3:0] flags_sync;
wire temp_ok;
wire lockout;
wire sd_ok;
wire pwm_req;

// reset values: temperature fine, lockout active, no shutdown
level_sync #(
    .WIDTH(4),
    .INIT(4'b0_1_1_0 | 4'b0001)
) u_sync (
    .clock_in(clock_in),
    .nrst_in(rst_n),
    .async_in({pwm_request_in, feedback_shutdown_input_in, supply_lockout_in, temp_ok_in}),
    .sync_out(flags_sync)
);

assign temp_ok = flags_sync[0];
assign lockout = flags_sync[1];
assign sd_ok = flags_sync[2];
assign pwm_req = flags_sync[3];

// ----------------------------------------------------------------
// control register
// ----------------------------------------------------------------
// bit 0: software shutdown request, ored with the pin
reg [31:0] ctrl_q;
wire sw_shutdown;
assign sw_shutdown = ctrl_q[0];

// ----------------------------------------------------------------
// supply cycle tracking and restart counter
// ----------------------------------------------------------------
reg lockout_prev_q;
reg powered_q;
reg [3:0] count_q;
reg [3:0] count_d;
reg running_q;
reg running_d;
// set when a shutdown is seen while the supply charges
reg rise_shut_q;
wire shutdown_req;
wire counter_rst_n;
wire startup_fall;
wire lockout_trip;

assign shutdown_req = ~sd_ok | sw_shutdown;
assign counter_rst_n = ~shutdown_req;
// start-up source turns off when lockout releases
assign startup_fall = lockout_prev_q & ~lockout;
assign lockout_trip = ~lockout_prev_q & lockout;

always @* begin
    count_d = count_q;
    running_d = running_q;
    if (!counter_rst_n) begin
        count_d = `COUNT_PRESET;
        running_d = 1'b0;
    end else if (startup_fall) begin
        if (!powered_q || rise_shut_q) begin
            // first release after power, or a shutdown lifted during this charge:
            // stay at seven for one more supply cycle, no switching
            count_d = `COUNT_PRESET;
            running_d = 1'b0;
        end else if (count_q == `COUNT_RUN) begin
            count_d = `COUNT_WRAP;
            running_d = 1'b0;
        end else begin
            count_d = count_q + 4'h1;
            running_d = (count_q + 4'h1) == `COUNT_RUN;
        end
    end else if (lockout_trip) begin
        running_d = 1'b0;
    end
end

always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        lockout_prev_q <= 1'b1;
        powered_q <= 1'b0;
        count_q <= `COUNT_PRESET;
        running_q <= 1'b0;
        rise_shut_q <= 1'b0;
    end else begin
        lockout_prev_q <= lockout;
        // cleared when the charge ends, set while a shutdown overlaps the charge
        if (shutdown_req && lockout) begin
            rise_shut_q <= 1'b1;
        end else if (startup_fall) begin
            rise_shut_q <= 1'b0;
        end
        if (startup_fall) begin
            powered_q <= 1'b1;
        end
        count_q <= count_d;
        running_q <= running_d;
    end
end

// ----------------------------------------------------------------
// outputs to the power stage
// ----------------------------------------------------------------
wire inhibit;
wire enabled;
assign inhibit = ~temp_ok | shutdown_req | ~running_q;
assign enabled = running_q & ~lockout & temp_ok & ~shutdown_req;

always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        gate_drive_out <= 1'b0;
        startup_enable_out <= 1'b1;
        pwm_enable_out <= 1'b0;
        clamp_enable_out <= 1'b1;
    end else begin
        gate_drive_out <= pwm_req & ~inhibit & ~lockout;
        startup_enable_out <= lockout;
        pwm_enable_out <= ~lockout;
        clamp_enable_out <= ~enabled;
    end
end

// ----------------------------------------------------------------
// interrupt status and mask
// ----------------------------------------------------------------
reg [`IRQ_WIDTH-1:0] irq_status_q;
reg [`IRQ_WIDTH-1:0] irq_mask_q;
reg temp_prev_q;
reg sd_prev_q;
reg run_prev_q;
wire [`IRQ_WIDTH-1:0] irq_events;
wire [`IRQ_WIDTH-1:0] irq_clear;
wire wr_fire;
reg [7:0] wr_addr_q;
reg [31:0] wr_data_q;

assign irq_events[`IRQ_OVERTEMP] = temp_prev_q & ~temp_ok;
assign irq_events[`IRQ_SHUTDOWN] = ~sd_prev_q & shutdown_req;
assign irq_events[`IRQ_LOCKOUT] = lockout_trip;
assign irq_events[`IRQ_RUN] = ~run_prev_q & running_q;
assign irq_clear = (wr_fire && wr_addr_q == `ADDR_IRQ_STATUS) ? wr_data_q[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        temp_prev_q <= 1'b1;
        sd_prev_q <= 1'b0;
        run_prev_q <= 1'b0;
        irq_status_q <= {`IRQ_WIDTH{1'b0}};
        irq_out <= 1'b0;
    end else begin
        temp_prev_q <= temp_ok;
        sd_prev_q <= shutdown_req;
        run_prev_q <= running_q;
        // set wins over clear
        irq_status_q <= (irq_status_q & ~irq_clear) | irq_events;
        irq_out <= |(irq_status_q & irq_mask_q);
    end
end

// ----------------------------------------------------------------
// axi4-lite write channel
// ----------------------------------------------------------------
reg aw_have_q;
reg w_have_q;
reg [3:0] wr_strb_q;
wire wr_ok;
wire [31:0] strb_mask;

assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid_out;
assign wr_ok = (wr_addr_q == `ADDR_CTRL) | (wr_addr_q == `ADDR_STATUS) |
               (wr_addr_q == `ADDR_IRQ_STATUS) | (wr_addr_q == `ADDR_IRQ_MASK);
assign strb_mask = {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}}, {8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};

always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        wr_addr_q <= 8'h00;
        wr_data_q <= 32'h0000_0000;
        wr_strb_q <= 4'h0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
        s_axi_bvalid_out <= 1'b0;
        s_axi_bresp_out <= `RESP_OKAY;
        ctrl_q <= `CTRL_RESET;
        irq_mask_q <= {`IRQ_WIDTH{1'b0}};
    end else begin
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_q <= 1'b1;
            wr_addr_q <= {s_axi_awaddr_in[7:2], 2'b00};
            s_axi_awready_out <= 1'b0;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_q <= 1'b1;
            wr_data_q <= s_axi_wdata_in;
            wr_strb_q <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
        end
        if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_addr_q == `ADDR_CTRL) begin
                ctrl_q <= ((ctrl_q & ~strb_mask) | (wr_data_q & strb_mask)) & 32'h0000_0001;
            end
            if (wr_addr_q == `ADDR_IRQ_MASK && wr_strb_q[0]) begin
                irq_mask_q <= wr_data_q[`IRQ_WIDTH-1:0];
            end
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// axi4-lite read channel
// ----------------------------------------------------------------
reg [31:0] rd_mux;
reg rd_ok;

always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case ({s_axi_araddr_in[7:2], 2'b00})
        `ADDR_CTRL: rd_mux = ctrl_q;
        `ADDR_STATUS: rd_mux = {20'h0_0000, count_q, 1'b0, clamp_enable_out, pwm_enable_out,
                                startup_enable_out, running_q, shutdown_req, lockout, temp_ok};
        `ADDR_IRQ_STATUS: rd_mux = {28'h000_0000, irq_status_q};
        `ADDR_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_q};
        default: rd_ok = 1'b0;
    endcase
end

always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_arready_out <= 1'b1;
        s_axi_rvalid_out <= 1'b0;
        s_axi_rdata_out <= 32'h0000_0000;
        s_axi_rresp_out <= `RESP_OKAY;
    end else begin
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_ok ? rd_mux : 32'h0000_0000;
            s_axi_rresp_out <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end
end

endmodule // fault_restart_sequencer

/* tb/frs_checker_asserts.sv */
// checker: drive, start-up and bus handshake properties on the sequencer ports
// assumes it is bound onto the sequencer top module
`timescale 1ns/1ns
module frs_checker (
    // watched ports
    input wire clock_in,
    input wire nrst_in,
    input wire temp_ok_in,
    input wire supply_lockout_in,
    input wire feedback_shutdown_input_in,
    input wire gate_drive_out,
    input wire startup_enable_out,
    input wire pwm_enable_out,
    input wire clamp_enable_out,
    input wire s_axi_arvalid_in,
    input wire s_axi_arready_out,
    input wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    input wire [31:0] s_axi_rdata_out
);
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    lock_gate_a: assert property (supply_lockout_in [*4] |-> !gate_drive_out)
        else $error("gate on during lockout");
    temp_gate_a: assert property (!temp_ok_in [*4] |-> !gate_drive_out)
        else $error("gate on while hot");
    sd_gate_a: assert property (!feedback_shutdown_input_in [*4] |-> !gate_drive_out)
        else $error("gate on in shutdown");
    charge_on_a: assert property (supply_lockout_in [*5] |-> startup_enable_out)
        else $error("start-up source off in lockout");
    charge_off_a: assert property (!supply_lockout_in [*5] |-> !startup_enable_out)
        else $error("start-up source on above threshold");
    run_outputs_a: assert property (gate_drive_out |-> pwm_enable_out && !clamp_enable_out)
        else $error("gate on with pwm off or clamp on");
    b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    ar_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##[1:4] s_axi_rvalid_out)
        else $error("read not answered");
    run_c: cover property (gate_drive_out);
    shut_c: cover property (!feedback_shutdown_input_in && startup_enable_out);
    hot_c: cover property (!temp_ok_in && supply_lockout_in);
endmodule // frs_checker

bind fault_restart_sequencer frs_checker u_chk (.*);

/* tb/supply_model.sv */
// supply model: start-up source charges the supply, switching holds it up
// assumes one clock; overload makes switching unable to sustain the supply
`timescale 1ns/1ns
module supply_model #(
    parameter int TOP = 20
) (
    input wire clock_in,
    input wire startup_enable_in,
    input wire gate_drive_in,
    input wire overload_in,
    output logic supply_lockout_out
);
    int v = 0;
    initial supply_lockout_out = 1'b1;
    // hysteresis between turn-on (TOP) and trip (0)
    always @(posedge clock_in) begin
        if (startup_enable_in && v < TOP)
            v <= v + 1;
        else if (!startup_enable_in && !(gate_drive_in && !overload_in) && v > 0)
            v <= v - 1;
        if (v == TOP)
            supply_lockout_out <= 1'b0;
        if (v == 0)
            supply_lockout_out <= 1'b1;
    end
endmodule // supply_model

/* tb/tb_top.sv */
// testbench: supply cycles, overload, shutdown, over-temperature and register access
// assumes the supply model on the far side and the bound checker
`timescale 1ns/1ns
`include "fault_restart_sequencer_defs.vh"
module tb_top;
    logic clock_in = 1'b0, nrst_in = 1'b0, temp_ok_in = 1'b1, overload = 1'b0;
    logic feedback_shutdown_input_in = 1'b1, pwm_request_in = 1'b1;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000, d;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [1:0] r;
    wire supply_lockout_in, gate_drive_out, startup_enable_out, pwm_enable_out, clamp_enable_out, irq_out;
    wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    int miscompares = 0, total_checks = 0, i;

    fault_restart_sequencer u_dut (.*);
    supply_model u_supply (.clock_in(clock_in), .startup_enable_in(startup_enable_out),
        .gate_drive_in(gate_drive_out), .overload_in(overload), .supply_lockout_out(supply_lockout_in));

    initial begin
        forever #50 clock_in = ~clock_in;
    end

    task automatic wrap_up;
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= v;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do begin
            @(posedge clock_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        s_axi_bready_in <= 1'b1;
        @(posedge clock_in);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
        @(posedge clock_in);
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do begin
            @(posedge clock_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b1;
        @(posedge clock_in);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        @(posedge clock_in);
    endtask

    // one supply cycle: wait for the next turn-on crossing
    task automatic fall;
        while (!supply_lockout_in) @(posedge clock_in);
        while (supply_lockout_in) @(posedge clock_in);
        repeat (6) @(posedge clock_in);
    endtask

    task automatic run(input logic [3:0] c, input logic g);
        rd(`ADDR_STATUS);
        chk("count", {28'h0, c}, {28'h0, d[11:8]});
        chk("gate", {31'h0, g}, {31'h0, gate_drive_out});
        chk("clamp", {31'h0, !g}, {31'h0, clamp_enable_out});
        chk("startup", 32'h0000_0000, {31'h0, startup_enable_out});
        chk("pwm", 32'h0000_0001, {31'h0, pwm_enable_out});
    endtask

    initial begin
        repeat (5000) @(posedge clock_in);
        miscompares++;
        wrap_up;
    end

    initial begin
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk("gate", 0, {31'h0, gate_drive_out});
        chk("startup", 1, {31'h0, startup_enable_out});
        chk("clamp", 1, {31'h0, clamp_enable_out});
        fall;
        run(`COUNT_PRESET, 1'b0);
        fall;
        run(`COUNT_RUN, 1'b1);
        overload <= 1'b1;
        for (i = 1; i < 8; i++) begin
            fall;
            run(i[3:0], 1'b0);
        end
        overload <= 1'b0;
        fall;
        run(`COUNT_RUN, 1'b1);
        wr(`ADDR_IRQ_MASK, 32'h0000_0002);
        feedback_shutdown_input_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        run(`COUNT_PRESET, 1'b0);
        chk("irq", 1, {31'h0, irq_out});
        wr(`ADDR_IRQ_STATUS, 32'h0000_000f);
        chk("irq", 0, {31'h0, irq_out});
        while (!supply_lockout_in) @(posedge clock_in);
        feedback_shutdown_input_in <= 1'b1;
        fall;
        run(`COUNT_PRESET, 1'b0);
        fall;
        run(`COUNT_RUN, 1'b1);
        wr(`ADDR_IRQ_MASK, 32'h0000_0001);
        temp_ok_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        chk("gate", 0, {31'h0, gate_drive_out});
        chk("irq", 1, {31'h0, irq_out});
        wr(`ADDR_IRQ_MASK, 32'h0000_0000);
        chk("irq", 0, {31'h0, irq_out});
        fall;
        chk("gate", 0, {31'h0, gate_drive_out});
        temp_ok_in <= 1'b1;
        for (i = 0; i < 9 && gate_drive_out !== 1'b1; i++) fall;
        chk("gate", 1, {31'h0, gate_drive_out});
        wr(`ADDR_CTRL, 32'h0000_0001);
        rd(`ADDR_CTRL);
        chk("ctrl", 32'h0000_0001, d);
        run(`COUNT_PRESET, 1'b0);
        rd(8'h40);
        chk("resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
        chk("data", 32'h0000_0000, d);
        wr(8'h40, 32'h0000_0001);
        chk("bresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
        wrap_up;
    end
endmodule // tb_top
